// ==== fbot_pkg.sv ====
// Package for the flash bus host controller: register map, fields, timing counts.
// Assumes a 125 MHz system clock; all counts derive from that rate.
package fbot_pkg;
  // Clock rate
  localparam int unsigned CLK_PERIOD_PS       = 8000;
  // Bus timing in ns as printed, and derived counts (least times round up)
  localparam int unsigned WRITE_PULSE_NS      = 50;
  localparam int unsigned WRITE_HIGH_NS       = 20;
  localparam int unsigned ADDR_SETUP_NS       = 50;
  localparam int unsigned READ_ACCESS_NS      = 70;
  localparam int unsigned RESET_LOW_NS        = 100;
  localparam int unsigned RESET_RECOVERY_NS   = 150;
  localparam int unsigned STATUS_DELAY_NS     = 100;
  localparam int unsigned WRITE_PULSE_CYC     = (WRITE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned WRITE_HIGH_CYC      = (WRITE_HIGH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned ADDR_SETUP_CYC      = (ADDR_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned READ_ACCESS_CYC     = (READ_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned RESET_LOW_CYC       = (RESET_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned RESET_RECOVERY_CYC  = (RESET_RECOVERY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Busy reports may lag the strobe: ignore ready until this many cycles pass
  localparam int unsigned STATUS_DELAY_CYC    = (STATUS_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Resume-to-suspend gap in us, and cycles
  localparam int unsigned RESUME_GAP_US       = 500;
  localparam int unsigned RESUME_GAP_CYC      = RESUME_GAP_US * 1000000 / CLK_PERIOD_PS;
  // Register offsets (byte addresses, one word each)
  localparam logic [3:0] REG_CTRL    = 4'h0;  // Command: bit0 go, bit1 write, bit2 reset, bit3 suspend
  localparam logic [3:0] REG_ADDR    = 4'h4;  // Flash word address
  localparam logic [3:0] REG_WDATA   = 4'h8;  // Write data
  localparam logic [3:0] REG_RDATA   = 4'hc;  // Read data, last read
  localparam logic [3:0] REG_STATUS  = 4'h0;  // Word 4: status (index via addr[5:2])
  // Register word indices
  localparam logic [3:0] IDX_CTRL    = 4'h0;
  localparam logic [3:0] IDX_ADDR    = 4'h1;
  localparam logic [3:0] IDX_WDATA   = 4'h2;
  localparam logic [3:0] IDX_RDATA   = 4'h3;
  localparam logic [3:0] IDX_STATUS  = 4'h4;
  localparam logic [3:0] IDX_IRQ_ST  = 4'h5;
  localparam logic [3:0] IDX_IRQ_EN  = 4'h6;
  localparam logic [3:0] IDX_IRQ_CLR = 4'h7;
  // Control field positions
  localparam int unsigned CTRL_GO     = 0;
  localparam int unsigned CTRL_WRITE  = 1;
  localparam int unsigned CTRL_RESET  = 2;
  localparam int unsigned CTRL_SUSP   = 3;
  // Flash status bits
  localparam int unsigned SR_READY    = 7;
  localparam int unsigned SR_ERASE    = 5;
  localparam int unsigned SR_PROGRAM  = 4;
  localparam int unsigned SR_SUPPLY   = 3;
  localparam int unsigned SR_PROTECT  = 1;
  // Interrupt event bits
  localparam int unsigned IRQ_DONE    = 0;
  localparam int unsigned IRQ_READY   = 1;
  localparam int unsigned IRQ_REFUSED = 2;
  localparam int unsigned IRQ_W       = 3;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
  // Sequencer states
  typedef enum logic [3:0] {
    FBOT_RST_HOLD, FBOT_RST_WAIT, FBOT_IDLE, FBOT_W_SETUP, FBOT_W_PULSE, FBOT_W_HIGH,
    FBOT_R_ACCESS, FBOT_R_DONE
  } fbot_state_type;
endpackage : fbot_pkg

// ==== fbot_host.sv ====
// Host controller for the flash half of a stacked memory: Avalon-MM register
// slave in front of an asynchronous flash bus sequencer.
// Assumes the flash pins are wired directly; ready/busy has an external pull-up.
// Functional notes
// - Write pulse between last fall, first rise
// - Keep supply enable until status success (not enforced here: supply_reg follows software writes to STATUS)
// - Resume to next suspend gap 500us
// - Hold reset low at least 100ns
// - Power-up: reset low after supply stable
// - Wait 150ns after reset before writing
`timescale 1ns/1ps
module fbot_host
  import fbot_pkg::*;
#(
  parameter int unsigned ADDR_W   = 22,  // Flash word address width
  parameter int unsigned DATA_W   = 16,  // Flash data width
  parameter int unsigned GAP_CYC  = RESUME_GAP_CYC  // Resume-to-suspend gap in cycles
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic [5:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  output logic      [31:0]         avs_readdata,
  output logic                     avs_waitrequest,
  output logic                     irq,
  output logic      [ADDR_W-1:0]   flash_addr,
  output logic                     flash_ce_n,
  output logic                     flash_we_n,
  output logic                     flash_oe_n,
  output logic                     flash_rst_n,
  output logic                     flash_supply_en,
  output logic      [DATA_W-1:0]   flash_dq_o,
  output logic                     flash_dq_oe,
  input  wire logic [DATA_W-1:0]   flash_dq_i,
  input  wire logic                flash_ready_busy_n
);
  import fbot_pkg::*;

  // Parameter checks
  initial begin
    if (ADDR_W < 1 || ADDR_W > 32) $error("fbot_host: ADDR_W out of range");
    if (DATA_W < 8 || DATA_W > 32) $error("fbot_host: DATA_W out of range");
    if (GAP_CYC < 1) $error("fbot_host: GAP_CYC must be positive");
  end

  // Reset release synchroniser
  logic [1:0] rst_sync_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rst_sync_reg <= 2'h0;
    else rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  wire logic rstn_i = rst_sync_reg[1];

  // Ready/busy pin: three flops, change accepted when last two agree
  logic [2:0] rb_sync_reg;
  logic       rb_filt_reg;
  always_ff @(posedge clk or negedge rstn_i) begin
    if (!rstn_i) begin
      rb_sync_reg <= 3'h7;
      rb_filt_reg <= 1'b1;
    end else begin
      rb_sync_reg <= {rb_sync_reg[1:0], flash_ready_busy_n};
      if (rb_sync_reg[2] == rb_sync_reg[1]) rb_filt_reg <= rb_sync_reg[2];
    end
  end

  // Software registers
  logic [ADDR_W-1:0]  addr_reg;        // Target address
  logic [DATA_W-1:0]  wdata_reg;       // Data to write
  logic [DATA_W-1:0]  rdata_reg;       // Last data read
  logic [IRQ_W-1:0]   irq_st_reg;      // Sticky events
  logic [IRQ_W-1:0]   irq_en_reg;      // Event enables
  logic               supply_reg;      // Program supply enable
  logic               suspend_reg;     // Last accepted command was a suspend
  logic               in_erase_reg;    // Last write command was not a suspend
  logic [31:0]        gap_cnt_reg;     // Cycles since last write command, held once it reaches GAP_CYC
  fbot_state_type     state_reg;
  logic [31:0]        cnt_reg;         // Phase counter
  logic               busy_wait_reg;   // Awaiting ready after a write command

  // Bus decode
  wire logic [3:0] idx       = avs_address[5:2];
  wire logic       wr_ctrl   = avs_write && idx == IDX_CTRL;
  wire logic       go        = wr_ctrl && avs_writedata[CTRL_GO];
  wire logic       seq_idle  = state_reg == FBOT_IDLE;
  // A command other than reset is refused while the sequencer runs, a non-suspend while the flash reports busy, or a suspend too soon
  wire logic       gap_short = avs_writedata[CTRL_SUSP] && in_erase_reg && gap_cnt_reg < GAP_CYC;
  wire logic       dev_busy  = busy_wait_reg || !rb_filt_reg;
  wire logic       refuse    = go && !avs_writedata[CTRL_RESET] &&
                               (!seq_idle || gap_short ||
                                (dev_busy && !avs_writedata[CTRL_SUSP]));
  wire logic       accept    = go && !refuse;
  wire logic       rst_cmd   = accept && avs_writedata[CTRL_RESET];
  wire logic       wr_cmd    = accept && !avs_writedata[CTRL_RESET] && avs_writedata[CTRL_WRITE];
  wire logic       rd_cmd    = accept && !avs_writedata[CTRL_RESET] && !avs_writedata[CTRL_WRITE];
  wire logic       op_done   = (state_reg == FBOT_W_HIGH || state_reg == FBOT_R_DONE) && cnt_reg == 0;
  wire logic       ready_rise = busy_wait_reg && cnt_reg == 0 && rb_filt_reg;
  // Reads answer combinationally in the same cycle: the slave is always ready
  assign avs_waitrequest = 1'b0;
  // Interrupt level
  assign irq = |(irq_st_reg & irq_en_reg);
  // Supply enable follows the software bit; software drops it only after success
  assign flash_supply_en = supply_reg;

  // Read mux
  always_comb begin
    case (idx)
      IDX_CTRL:   avs_readdata = {28'h0, suspend_reg, !flash_rst_n, 1'b0, !seq_idle};
      IDX_ADDR:   avs_readdata = 32'(addr_reg);
      IDX_WDATA:  avs_readdata = 32'(wdata_reg);
      IDX_RDATA:  avs_readdata = 32'(rdata_reg);
      IDX_STATUS: avs_readdata = {29'h0, supply_reg, dev_busy, rb_filt_reg};
      IDX_IRQ_ST: avs_readdata = 32'(irq_st_reg);
      IDX_IRQ_EN: avs_readdata = 32'(irq_en_reg);
      default:    avs_readdata = UNMAPPED_DATA;
    endcase
  end

  // Register writes
  always_ff @(posedge clk or negedge rstn_i) begin
    if (!rstn_i) begin
      addr_reg    <= '0;
      wdata_reg   <= '0;
      irq_en_reg  <= '0;
      supply_reg  <= 1'b0;
      suspend_reg <= 1'b0;
    end else begin
      if (avs_write && idx == IDX_ADDR) addr_reg <= avs_writedata[ADDR_W-1:0];
      if (avs_write && idx == IDX_WDATA) wdata_reg <= avs_writedata[DATA_W-1:0];
      if (avs_write && idx == IDX_IRQ_EN) irq_en_reg <= avs_writedata[IRQ_W-1:0];
      // Supply enable: software keeps it set until status shows success
      if (avs_write && idx == IDX_STATUS) supply_reg <= avs_writedata[2];
      if (accept) suspend_reg <= avs_writedata[CTRL_SUSP];
    end
  end

  // Sticky events; set wins over clear
  always_ff @(posedge clk or negedge rstn_i) begin
    if (!rstn_i) irq_st_reg <= '0;
    else begin
      irq_st_reg <= (irq_st_reg &
                     ~((avs_write && idx == IDX_IRQ_CLR) ? avs_writedata[IRQ_W-1:0] : '0))
                    | {refuse, ready_rise, op_done};
    end
  end

  // Resume-to-suspend spacing: any accepted write command restarts the gap timer
  always_ff @(posedge clk or negedge rstn_i) begin
    if (!rstn_i) begin
      gap_cnt_reg  <= '0;
      in_erase_reg <= 1'b0;
    end else if (wr_cmd) begin
      gap_cnt_reg  <= '0;
      in_erase_reg <= !avs_writedata[CTRL_SUSP];
    end else if (gap_cnt_reg < GAP_CYC) gap_cnt_reg <= gap_cnt_reg + 32'h1;
  end

  // Busy window: ready pin may stay high briefly after the strobe
  always_ff @(posedge clk or negedge rstn_i) begin
    if (!rstn_i) busy_wait_reg <= 1'b0;
    else if (state_reg == FBOT_W_HIGH && cnt_reg == 0) busy_wait_reg <= 1'b1;
    else if (ready_rise) busy_wait_reg <= 1'b0;
  end

  // Bus sequencer
  always_ff @(posedge clk or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg   <= FBOT_RST_HOLD;
      cnt_reg     <= 32'(RESET_LOW_CYC);
      flash_rst_n <= 1'b0;
      flash_ce_n  <= 1'b1;
      flash_we_n  <= 1'b1;
      flash_oe_n  <= 1'b1;
      flash_dq_oe <= 1'b0;
      flash_dq_o  <= '0;
      flash_addr  <= '0;
      rdata_reg   <= '0;
    end else begin
      if (cnt_reg != 0 && !(busy_wait_reg && state_reg == FBOT_IDLE)) cnt_reg <= cnt_reg - 32'h1;
      if (busy_wait_reg && state_reg == FBOT_IDLE && cnt_reg != 0) cnt_reg <= cnt_reg - 32'h1;
      case (state_reg)
        FBOT_RST_HOLD: begin
          // Reset held low from power-up or a reset command for the least pulse
          if (cnt_reg == 0) begin
            flash_rst_n <= 1'b1;
            cnt_reg     <= 32'(RESET_RECOVERY_CYC);
            state_reg   <= FBOT_RST_WAIT;
          end
        end
        FBOT_RST_WAIT: begin
          // No strobe until recovery has passed
          if (cnt_reg == 0) state_reg <= FBOT_IDLE;
        end
        FBOT_IDLE: begin
          if (rst_cmd) begin
            flash_rst_n <= 1'b0;
            cnt_reg     <= 32'(RESET_LOW_CYC);
            state_reg   <= FBOT_RST_HOLD;
          end else if (wr_cmd) begin
            flash_addr  <= addr_reg;
            flash_dq_o  <= wdata_reg;
            flash_dq_oe <= 1'b1;
            flash_ce_n  <= 1'b0;
            cnt_reg     <= 32'(ADDR_SETUP_CYC - WRITE_PULSE_CYC);
            state_reg   <= FBOT_W_SETUP;
          end else if (rd_cmd) begin
            flash_addr  <= addr_reg;
            flash_ce_n  <= 1'b0;
            flash_oe_n  <= 1'b0;
            cnt_reg     <= 32'(READ_ACCESS_CYC);
            state_reg   <= FBOT_R_ACCESS;
          end
        end
        FBOT_W_SETUP: begin
          // Chip select already low; write strobe falls last and opens the pulse
          if (cnt_reg == 0) begin
            flash_we_n <= 1'b0;
            cnt_reg    <= 32'(WRITE_PULSE_CYC);
            state_reg  <= FBOT_W_PULSE;
          end
        end
        FBOT_W_PULSE: begin
          // Write strobe rises first and closes the pulse
          if (cnt_reg == 0) begin
            flash_we_n <= 1'b1;
            cnt_reg    <= 32'(WRITE_HIGH_CYC);
            state_reg  <= FBOT_W_HIGH;
          end
        end
        FBOT_W_HIGH: begin
          // Release bus; hold a guard before ready can be trusted
          flash_ce_n <= 1'b1;
          if (cnt_reg == 0) begin
            flash_dq_oe <= 1'b0;
            cnt_reg     <= 32'(STATUS_DELAY_CYC);
            state_reg   <= FBOT_IDLE;
          end
        end
        FBOT_R_ACCESS: begin
          if (cnt_reg == 0) begin
            rdata_reg  <= flash_dq_i;
            flash_ce_n <= 1'b1;
            flash_oe_n <= 1'b1;
            state_reg  <= FBOT_R_DONE;
          end
        end
        FBOT_R_DONE: state_reg <= FBOT_IDLE;
        default: state_reg <= FBOT_IDLE;
      endcase
    end
  end
endmodule : fbot_host

// ==== fbot_host_sva.sv ====
// Checker on the flash pins of fbot_host.
// Assumes one clock domain; it sees only the top-level ports.
`timescale 1ns/1ps
module fbot_host_sva
  import fbot_pkg::*;
#(
  parameter int unsigned ADDR_W  = 22,
  parameter int unsigned DATA_W  = 16,
  parameter int unsigned GAP_CYC = RESUME_GAP_CYC
) (
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic [5:0]        avs_address,
  input wire logic              avs_write,
  input wire logic [31:0]       avs_writedata,
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic              flash_ce_n,
  input wire logic              flash_we_n,
  input wire logic              flash_oe_n,
  input wire logic              flash_rst_n,
  input wire logic [DATA_W-1:0] flash_dq_o,
  input wire logic              flash_dq_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire wp_n = flash_ce_n | flash_we_n;  // Effective strobe, low while writing
  // No reset: reset time also counts as hold time on the pin
  int unsigned low_cnt = 0;             // Cycles flash reset held low
  int unsigned hi_cnt  = 0;             // Cycles since flash reset released
  int unsigned gap_cnt = 32'hffff;      // Cycles since last strobe end
  wire susp_early = avs_write && avs_address[5:2] == IDX_CTRL && avs_writedata[CTRL_SUSP]
                    && avs_writedata[CTRL_GO] && gap_cnt < GAP_CYC;
  // Helper counters
  always @(posedge clk) begin
    low_cnt <= flash_rst_n ? 0 : low_cnt + 1;
    hi_cnt  <= flash_rst_n ? hi_cnt + 1 : 0;
    gap_cnt <= $rose(wp_n) ? 0 : gap_cnt + 1;
  end
  sequence s_low;
    (!wp_n)[*7];
  endsequence
  sequence s_high;
    wp_n[*3];
  endsequence
  a_pulse_width: assert property ($fell(wp_n) |-> s_low)
    else $error("write pulse shorter than minimum");
  a_pulse_high: assert property ($rose(wp_n) |-> s_high)
    else $error("write pulse high time too short");
  a_pulse_stable: assert property (!wp_n |-> $stable(flash_addr) && $stable(flash_dq_o) && flash_dq_oe)
    else $error("address or data moved during write pulse");
  a_no_contention: assert property (flash_dq_oe |-> flash_oe_n)
    else $error("host drives data while flash output enabled");
  a_reset_hold: assert property ($rose(flash_rst_n) |-> low_cnt >= RESET_LOW_CYC)
    else $error("flash reset pulse too short");
  a_reset_recover: assert property ($fell(wp_n) |-> hi_cnt >= RESET_RECOVERY_CYC)
    else $error("write began too soon after flash reset");
  a_reset_quiet: assert property (!flash_rst_n |-> wp_n && flash_oe_n)
    else $error("strobes active while flash reset low");
  a_suspend_gap: assert property (susp_early |=> (!$fell(flash_we_n))[*8])
    else $error("suspend issued inside resume gap");
endmodule : fbot_host_sva

bind fbot_host fbot_host_sva #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .GAP_CYC(GAP_CYC)) u_sva (
  .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .flash_addr(flash_addr), .flash_ce_n(flash_ce_n),
  .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n), .flash_rst_n(flash_rst_n),
  .flash_dq_o(flash_dq_o), .flash_dq_oe(flash_dq_oe));

// ==== fbot_flash_model.sv ====
// Behavioural flash device: strobe decode, busy pin, small array.
// Assumes the bench clock; run times are cycle counts.
`timescale 1ns/1ps
module fbot_flash_model #(
  parameter int unsigned BUSY_CYC = 200,  // Program or erase run time
  parameter int unsigned SUSP_CYC = 20    // Suspend latency
) (
  input  wire logic        clk,
  input  wire logic [3:0]  addr,          // Low address bits only
  input  wire logic        ce_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic        rst_n,         // Flash reset pin
  input  wire logic [15:0] dq_in,         // Resolved data bus
  output logic      [15:0] dq_out,        // Level seen while host not driving
  output logic             rb_pull_low    // Open-drain busy enable
);
  logic [15:0] mem [16];                  // Word array
  logic [15:0] last = 16'h0000;           // Last word driven
  int unsigned busy = 0;                  // Remaining busy cycles
  logic        wp_q = 1'b1;               // Previous strobe level
  wire wp_n = ce_n | we_n;                // Later fall to first rise
  wire rd   = !ce_n && !oe_n && rst_n;
  initial foreach (mem[i]) mem[i] = 16'h0000;  // Readable at once after power-up
  // Command latch at strobe end; reset aborts at once
  always @(posedge clk) begin
    wp_q <= wp_n;
    if (rd) last <= dq_out;
    if (!rst_n) busy <= 0;
    else if (wp_n && !wp_q) begin
      mem[addr] <= dq_in;
      if (dq_in[7:0] == 8'h40 || dq_in[7:0] == 8'h20) busy <= BUSY_CYC;
      else if (dq_in[7:0] == 8'hb0 && busy > SUSP_CYC) busy <= SUSP_CYC;
    end else if (busy > 0) busy <= busy - 1;
  end
  // Status bit 7 low while busy; released bus flips every read
  assign dq_out = rd ? (busy != 0 ? 16'h0000 : mem[addr]) : ~last;
  assign rb_pull_low = busy != 0;
endmodule : fbot_flash_model

// ==== testbench.sv ====
// Self-checking bench: fbot_host on Avalon-MM, flash model on the pins.
// Assumes one 125 MHz clock and a shortened resume gap.
`timescale 1ns/1ps
module testbench;
  import fbot_pkg::*;
  localparam int unsigned GAP = 50;          // Shortened resume gap
  logic clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [5:0]  avs_address = 6'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic        avs_waitrequest, irq, ce_n, we_n, oe_n, frst_n, dq_oe, rb_low, sup_en;
  logic [21:0] faddr;
  logic [15:0] dq_o, dq_m;
  wire  [15:0] dq = dq_oe ? dq_o : dq_m;    // Host wins while driving
  wire         rb_n = !rb_low;              // External pull-up
  int n_errors = 0, n_compared = 0;
  fbot_host #(.ADDR_W(22), .DATA_W(16), .GAP_CYC(GAP)) dut (.clk(clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .flash_addr(faddr), .flash_ce_n(ce_n),
    .flash_we_n(we_n), .flash_oe_n(oe_n), .flash_rst_n(frst_n), .flash_supply_en(sup_en),
    .flash_dq_o(dq_o), .flash_dq_oe(dq_oe), .flash_dq_i(dq), .flash_ready_busy_n(rb_n));
  // Long run time so a suspend lands while the erase is still busy
  fbot_flash_model #(.BUSY_CYC(400)) flash (.clk(clk), .addr(faddr[3:0]), .ce_n(ce_n), .we_n(we_n),
    .oe_n(oe_n), .rst_n(frst_n), .dq_in(dq), .dq_out(dq_m), .rb_pull_low(rb_low));
  function automatic logic [31:0] exp_read(input logic [15:0] w);
    return {16'h0000, w};
  endfunction : exp_read
  task automatic wrap_up;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // One Avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) begin
      n++;
      if (n > 100) begin
        chk(32'h1, 32'h0);
        wrap_up();
      end
      @(posedge clk);
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask : bus
  // Bounded poll until masked register equals value
  task automatic poll(input logic [5:0] a, input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    do begin
      bus(1'b0, a, 32'h0);
      n++;
    end while ((rd & m) !== v && n < 400);
    if ((rd & m) !== v) begin
      chk(rd & m, v);
      wrap_up();
    end
  endtask : poll
  task automatic op(input logic [3:0] a, input logic [15:0] w, input logic [3:0] c);
    bus(1'b1, 6'h04, {28'h0, a});
    bus(1'b1, 6'h08, {16'h0, w});
    bus(1'b1, 6'h00, {28'h0, c});
    poll(6'h00, 32'h1, 32'h0);
  endtask : op
  task automatic wr_rd(input logic [3:0] a, input logic [15:0] w);
    op(a, w, 4'h3);
    poll(6'h10, 32'h2, 32'h0);
    op(a, 16'h0000, 4'h1);
    bus(1'b0, 6'h0c, 32'h0);
    chk(rd, exp_read(w));
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, 6'h1c, 32'h7);
    chk({31'h0, irq}, 32'h0);
  endtask : wr_rd
  initial begin
    forever #4 clk = ~clk;
  end
  // Main sequence
  initial begin
    logic [15:0] w;
    void'($urandom(32'hb49e));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    poll(6'h00, 32'h1, 32'h0);
    bus(1'b0, 6'h14, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 6'h20, 32'h0);
    chk(rd, UNMAPPED_DATA);
    bus(1'b1, 6'h10, 32'h4);
    chk({31'h0, sup_en}, 32'h1);
    bus(1'b1, 6'h18, 32'h7);
    wr_rd(4'hf, 16'hffff);
    wr_rd(4'h0, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      w = 16'($urandom());
      if (w[7:0] == 8'h40 || w[7:0] == 8'h20 || w[7:0] == 8'hb0) w[7:0] = 8'h11;
      wr_rd(4'($urandom_range(15, 0)), w);
    end
    bus(1'b1, 6'h18, 32'h0);  // Masked: event stays silent
    op(4'h0, 16'h0000, 4'h1);
    chk({31'h0, irq}, 32'h0);
    bus(1'b0, 6'h14, 32'h0);
    chk(rd & 32'h1, 32'h1);
    bus(1'b1, 6'h18, 32'h7);
    chk({31'h0, irq}, 32'h1);
    op(4'h2, 16'h0020, 4'h3);  // Erase starts a long busy
    bus(1'b1, 6'h1c, 32'h7);
    op(4'h3, 16'h00b0, 4'hb);  // Suspend write inside the gap
    poll(6'h14, 32'h4, 32'h4);
    bus(1'b1, 6'h1c, 32'h7);
    op(4'h3, 16'h1234, 4'h3);
    poll(6'h14, 32'h4, 32'h4);
    bus(1'b0, 6'h10, 32'h0);
    chk(rd & 32'h6, 32'h6);
    bus(1'b1, 6'h1c, 32'h7);
    repeat (2 * GAP) @(posedge clk);
    op(4'h3, 16'h00b0, 4'hb);
    poll(6'h10, 32'h3, 32'h1);
    op(4'h4, 16'h0040, 4'h3);  // Program, then reset mid-run
    bus(1'b1, 6'h00, 32'h5);
    poll(6'h00, 32'h1, 32'h0);
    poll(6'h10, 32'h3, 32'h1);
    wr_rd(4'h5, 16'h5a5a);
    wrap_up();
  end
endmodule : testbench
